// ### hw/asp_fifo.sv
// Small valid/ready FIFO for received samples
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### hw/asp_map.svh
// Address map, field positions, reset values and counts of the serial port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_IDX_CTRL1 8'h04
`define ASP_IDX_CTRL2 8'h05
`define ASP_IDX_STATUS 8'h10
`define ASP_IDX_DATA 8'h11
`define ASP_RST_CTRL1 8'h11
`define ASP_RST_CTRL2 8'h00
`define ASP_B_INVERT 7
`define ASP_B_EDGE 6
`define ASP_F_CPC_HI 5
`define ASP_F_CPC_LO 3
`define ASP_B_STYLE 2
`define ASP_B_FORMAT 1
`define ASP_B_FRAMING 0
`define ASP_B_WIDTH 7
`define ASP_B_AUTO 4
`define ASP_F_SLOT_HI 3
`define ASP_F_SLOT_LO 0
`define ASP_B_VALID 24
`define ASP_CPC_16 3'h0
`define ASP_CPC_24 3'h1
`define ASP_CPC_32 3'h2
`define ASP_CPC_48 3'h3
`define ASP_CPC_64 3'h4
`define ASP_LEN_16 10'h010
`define ASP_LEN_24 10'h018
`define ASP_LEN_32 10'h020
`define ASP_LEN_48 10'h030
`define ASP_LEN_64 10'h040
`define ASP_W24 10'h018
`define ASP_W16 10'h010
`define ASP_POS_MAX 10'h3ff
`define ASP_FIFO_DEPTH 4
`define ASP_STRAP_WAIT 2'h2
`define ASP_NEG_MIN 24'h800000
`define ASP_POS_FULL 24'h7fffff
`endif

// ### hw/asp_pkg.sv
// Types shared by the serial audio port
package asp_pkg;
  typedef enum logic [0:0] {
    ASP_STEREO = 1'b0,
    ASP_TDM = 1'b1
  } asp_framing_t;
  typedef logic [23:0] asp_sample_t;
  typedef logic [9:0] asp_pos_t;
endpackage

// ### hw/asp_top.sv
// Serial audio input port with format control and APB registers
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_top
  import asp_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial audio link
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_audio_in,
  // Address select strap
  input wire logic [1:0] addr_select,
  // Captured sample stream
  output logic [23:0] sample_out,
  output logic sample_strobe
);
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic overflow_q;
  logic [1:0] strap_q;
  logic strap_done_q;
  logic wr_seen_q;
  logic [23:0] sample_q;
  logic strobe_q;

  // Pin synchronisers: clock, sync, data, two strap bits
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  assign pin_raw = {addr_select, serial_audio_in, frame_sync, bit_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  logic bclk_s;
  logic fs_s;
  logic sd_s;
  logic bclk_prev_q;
  logic fs_prev_q;
  assign bclk_s = pin_s2_q[0];
  assign fs_s = pin_s2_q[1];
  assign sd_s = pin_s2_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_s;
    end
  end

  // Configuration fields
  logic output_invert;
  logic capture_edge_select;
  logic [2:0] clocks_per_chip;
  logic frame_sync_style;
  logic data_delay_format;
  asp_framing_t framing_select;
  logic width16;
  logic auto_slot;
  logic [3:0] slot_field;
  assign output_invert = ctrl1_q[`ASP_B_INVERT];
  assign capture_edge_select = ctrl1_q[`ASP_B_EDGE];
  assign clocks_per_chip = ctrl1_q[`ASP_F_CPC_HI:`ASP_F_CPC_LO];
  assign frame_sync_style = ctrl1_q[`ASP_B_STYLE];
  assign data_delay_format = ctrl1_q[`ASP_B_FORMAT];
  assign framing_select = asp_framing_t'(ctrl1_q[`ASP_B_FRAMING]);
  assign width16 = ctrl2_q[`ASP_B_WIDTH];
  assign auto_slot = ctrl2_q[`ASP_B_AUTO];
  assign slot_field = ctrl2_q[`ASP_F_SLOT_HI:`ASP_F_SLOT_LO];

  // Capture edge of the sampled bit clock
  logic cap_w;
  assign cap_w = capture_edge_select ? (bclk_prev_q && !bclk_s)
                                     : (!bclk_prev_q && bclk_s);

  // Slot length; undefined codes fall back to 32
  asp_pos_t slot_len_w;
  always_comb begin
    unique case (clocks_per_chip)
      `ASP_CPC_16: slot_len_w = `ASP_LEN_16;
      `ASP_CPC_24: slot_len_w = `ASP_LEN_24;
      `ASP_CPC_32: slot_len_w = `ASP_LEN_32;
      `ASP_CPC_48: slot_len_w = `ASP_LEN_48;
      `ASP_CPC_64: slot_len_w = `ASP_LEN_64;
      default: slot_len_w = `ASP_LEN_32;
    endcase
  end

  // Strap caught once both sync stages hold the pin, never in the reset branch
  logic [1:0] strap_age_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_age_q <= 2'h0;
      strap_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (strap_age_q != `ASP_STRAP_WAIT) begin
      strap_age_q <= strap_age_q + 2'h1;
    end else if (!strap_done_q) begin
      strap_q <= pin_s2_q[4:3];
      strap_done_q <= 1'b1;
    end
  end

  logic [3:0] slot_sel_w;
  assign slot_sel_w = auto_slot ? {2'h0, strap_q} : slot_field;

  // Frame-sync reference edges
  logic fs_edge_w;
  logic sync_w;
  logic left_lvl;
  assign fs_edge_w = (fs_s != fs_prev_q);
  assign left_lvl = frame_sync_style;
  // TDM: both pulsed and half-duty styles start a frame on the rising edge
  assign sync_w = (framing_select == ASP_TDM) ? (fs_s && !fs_prev_q)
                                              : fs_edge_w;

  // Bit position inside the channel or frame; no frame length is checked
  asp_pos_t pos_q;
  asp_pos_t bitpos_w;
  logic bit_ok_w;
  logic in_left_q;
  always_comb begin
    bitpos_w = pos_q;
    bit_ok_w = 1'b1;
    if (sync_w) begin
      bitpos_w = '0;
      bit_ok_w = data_delay_format;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev_q <= 1'b0;
      pos_q <= '0;
      in_left_q <= 1'b0;
    end else if (cap_w) begin
      fs_prev_q <= fs_s;
      if (sync_w) begin
        pos_q <= data_delay_format ? 10'h001 : 10'h000;
        in_left_q <= (fs_s == left_lvl);
      end else if (pos_q != `ASP_POS_MAX) begin
        pos_q <= pos_q + 10'h001;
      end
    end
  end

  // Window of the wanted word
  asp_pos_t word_w;
  asp_pos_t start_w;
  logic active_w;
  logic in_word_w;
  logic last_w;
  assign word_w = width16 ? `ASP_W16 : `ASP_W24;
  assign start_w = (framing_select == ASP_TDM) ? 10'(slot_sel_w * slot_len_w) : '0;
  assign active_w = (framing_select == ASP_TDM) || in_left_q || (sync_w &&
                    (fs_s == left_lvl));
  assign in_word_w = cap_w && bit_ok_w && active_w && (bitpos_w >= start_w) &&
                     (bitpos_w < 10'(start_w + word_w));
  assign last_w = in_word_w && (bitpos_w == 10'(start_w + word_w - 10'h001));

  logic [23:0] shift_q;
  logic [23:0] shift_d;
  assign shift_d = {shift_q[22:0], sd_s};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 24'h0;
    end else if (in_word_w) begin
      shift_q <= shift_d;
    end
  end

  // Align, then invert with saturation of the most negative value
  asp_sample_t aligned_w;
  asp_sample_t proc_w;
  assign aligned_w = width16 ? {shift_d[15:0], 8'h00} : shift_d;
  always_comb begin
    proc_w = aligned_w;
    if (output_invert) begin
      proc_w = (aligned_w == `ASP_NEG_MIN) ? `ASP_POS_FULL : 24'(-aligned_w);
    end
  end

  // FIFO between capture and software; full drops the word and flags it
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  asp_sample_t fifo_out_data;

  asp_fifo #(
    .WIDTH(24),
    .DEPTH(`ASP_FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(last_w),
    .in_ready(fifo_in_ready),
    .in_data(proc_w),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= 24'h0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= last_w;
      if (last_w) begin
        sample_q <= proc_w;
      end
    end
  end

  // APB decode: one wait-free access, answer registered in setup
  logic setup_w;
  logic done_w;
  logic [7:0] idx_w;
  logic mapped_w;
  assign setup_w = psel && !penable && !pready_q;
  assign done_w = psel && penable && pready_q;
  assign idx_w = paddr[9:2];
  assign mapped_w = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                    ((idx_w == `ASP_IDX_CTRL1) || (idx_w == `ASP_IDX_CTRL2) ||
                     (idx_w == `ASP_IDX_STATUS) || (idx_w == `ASP_IDX_DATA));
  assign fifo_out_ready = done_w && !pwrite && !pslverr_q && (idx_w == `ASP_IDX_DATA);

  logic [31:0] rd_w;
  always_comb begin
    rd_w = 32'h0;
    unique case (idx_w)
      `ASP_IDX_CTRL1: rd_w = {24'h0, ctrl1_q};
      `ASP_IDX_CTRL2: rd_w = {24'h0, ctrl2_q};
      `ASP_IDX_STATUS: rd_w = {28'h0, strap_q, fifo_out_valid, overflow_q};
      `ASP_IDX_DATA: rd_w = {7'h0, fifo_out_valid, fifo_out_data};
      default: rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (setup_w) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped_w;
      prdata_q <= (pwrite || !mapped_w) ? 32'h0 : rd_w;
    end else if (done_w) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  logic wr_w;
  assign wr_w = done_w && pwrite && !pslverr_q && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= `ASP_RST_CTRL1;
      ctrl2_q <= `ASP_RST_CTRL2;
      wr_seen_q <= 1'b0;
    end else if (wr_w) begin
      wr_seen_q <= 1'b1;
      if (idx_w == `ASP_IDX_CTRL1) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (idx_w == `ASP_IDX_CTRL2) begin
        ctrl2_q <= pwdata[7:0];
      end
    end
  end

  // Overflow sticky; a new drop wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
    end else if (last_w && !fifo_in_ready) begin
      overflow_q <= 1'b1;
    end else if (wr_w && (idx_w == `ASP_IDX_STATUS) && pwdata[0]) begin
      overflow_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sample_out = sample_q;
  assign sample_strobe = strobe_q;

  // Checks
  property p_invert;
    @(posedge pclk) disable iff (!presetn)
    (last_w && output_invert && aligned_w != `ASP_NEG_MIN) |=>
      (sample_q == 24'($past(-aligned_w))) && strobe_q;
  endproperty
  a_invert: assert property (p_invert) else $error("sample not negated");
  property p_edge;
    @(posedge pclk) disable iff (!presetn)
    cap_w |-> (bclk_s == !capture_edge_select) && (bclk_prev_q == capture_edge_select);
  endproperty
  a_edge: assert property (p_edge) else $error("capture on wrong edge");
  property p_slot64;
    @(posedge pclk) disable iff (!presetn)
    (clocks_per_chip == `ASP_CPC_64) |-> (slot_len_w == `ASP_LEN_64);
  endproperty
  a_slot64: assert property (p_slot64) else $error("slot length not 64");
  property p_reset_cfg;
    @(posedge pclk) disable iff (!presetn)
    !wr_seen_q |-> (ctrl1_q == `ASP_RST_CTRL1) && (framing_select == ASP_TDM);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");
  property p_left;
    @(posedge pclk) disable iff (!presetn)
    (cap_w && sync_w && framing_select == ASP_STEREO) |=>
      (in_left_q == ($past(fs_s) == $past(frame_sync_style)));
  endproperty
  a_left: assert property (p_left) else $error("left channel level wrong");
  property p_delay;
    @(posedge pclk) disable iff (!presetn)
    (cap_w && sync_w) |=> (pos_q == {9'h0, $past(data_delay_format)});
  endproperty
  a_delay: assert property (p_delay) else $error("data delay wrong");
  property p_width16;
    @(posedge pclk) disable iff (!presetn)
    (last_w && width16) |=> (sample_q[7:0] == 8'h00);
  endproperty
  a_width16: assert property (p_width16) else $error("16-bit word misaligned");
  property p_auto;
    @(posedge pclk) disable iff (!presetn)
    $rose(strap_done_q) |-> (strap_q == $past(pin_s2_q[4:3])) &&
      ($past(strap_age_q) == `ASP_STRAP_WAIT);
  endproperty
  a_auto: assert property (p_auto) else $error("strap caught too early");
  property p_window;
    @(posedge pclk) disable iff (!presetn)
    (in_word_w && framing_select == ASP_TDM) |->
      (bitpos_w >= 10'(slot_sel_w * slot_len_w));
  endproperty
  a_window: assert property (p_window) else $error("bit outside own slot");
endmodule

// ### sim/asp_host_model.sv
// Host audio processor model driving the serial audio link
`timescale 1ns/1ps
module asp_host_model (
  // Serial audio link
  output logic bit_clock,
  output logic frame_sync,
  output logic serial_audio_in
);
  int half_ns = 400;
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    serial_audio_in = 1'b0;
  end
  // One frame; nsl 0 means stereo, slen is then the half-frame length
  task automatic send(input logic [7:0] c1, input logic [7:0] c2, input logic [23:0] w,
                      input int slen, input int nsl, input int sel);
    int total, start, idx, wb;
    logic idle, lead;
    idle = c1[6];  // Capture edge is the one leaving idle
    wb = c2[7] ? 16 : 24;
    total = (nsl == 0) ? 2 * slen : nsl * slen;  // Slots as configured
    start = (nsl == 0) ? 0 : sel * slen;
    lead = (nsl == 0) ? c1[2] : 1'b1;  // Left level or rising sync
    #13;  // Keep pin changes off the pclk edges
    bit_clock = idle;
    // One lead-in clock so the frame edge is always a real transition
    for (int p = -1; p < total; p++) begin
      idx = p - start - (c1[1] ? 0 : 1);  // One-bit delay unless justified
      if (p < 0)
        frame_sync = ~lead;
      else if (nsl == 0)
        frame_sync = (p < slen) ? lead : ~lead;
      else
        frame_sync = c1[2] ? (p < total / 2) : (p == 0);  // Style as set
      serial_audio_in = (idx >= 0 && idx < wb) ? w[wb - 1 - idx] : p[0];
      #(half_ns);
      bit_clock = ~idle;
      #(half_ns);
      bit_clock = idle;
    end
    frame_sync = (nsl == 0) ? ~lead : 1'b0;
    serial_audio_in = ~serial_audio_in;  // Released line shows no stale bit
  endtask
endmodule

// ### sim/asp_top_tb.sv
// Self-checking bench for the serial audio port
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_top_tb
  import asp_pkg::*;
;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [23:0] w;
    int slen;
    int nsl;
    int sel;
  } asp_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic bit_clock, frame_sync, serial_audio_in, sample_strobe;
  logic [1:0] addr_select;
  logic [23:0] sample_out;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  asp_row_t rows[10] = '{
    '{8'h11, 8'h00, 24'h123456, 32, 2, 0}, '{8'h01, 8'h81, 24'h00abcd, 16, 4, 1},
    '{8'h09, 8'h02, 24'h654321, 24, 4, 2}, '{8'h1b, 8'h01, 24'h3c5a69, 48, 2, 1},
    '{8'h25, 8'h00, 24'h0f0f0f, 64, 2, 0}, '{8'hd1, 8'h00, 24'h123456, 32, 2, 0},
    '{8'h10, 8'h80, 24'h00beef, 25, 0, 0}, '{8'h56, 8'h00, 24'h5a5a5a, 30, 0, 0},
    '{8'h01, 8'h9f, 24'h00c3a5, 16, 4, 2}, '{8'h91, 8'h00, 24'h800000, 32, 2, 0}};

  asp_top u_asp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_audio_in(serial_audio_in), .addr_select(addr_select),
    .sample_out(sample_out), .sample_strobe(sample_strobe));
  asp_host_model u_asp_host_model (.bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_audio_in(serial_audio_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous ceiling: all frames together take about 10000 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop;
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic asp_sample_t expect_of(input logic [7:0] c1, input logic [7:0] c2,
                                            input asp_sample_t w);
    asp_sample_t v;
    v = c2[7] ? {w[15:0], 8'h00} : w;
    // Most negative value saturates, it has no positive twin
    if (c1[7])
      v = (v == 24'h800000) ? 24'h7fffff : -v;
    return v;
  endfunction

  task automatic run_row(input asp_row_t r);
    logic [31:0] q;
    logic e;
    asp_sample_t x;
    int k;
    x = expect_of(r.c1, r.c2, r.w);
    k = 0;
    apb(1'b1, ra(`ASP_IDX_CTRL1), {24'h0, r.c1}, q, e);
    apb(1'b1, ra(`ASP_IDX_CTRL2), {24'h0, r.c2}, q, e);
    fork
      u_asp_host_model.send(r.c1, r.c2, r.w, r.slen, r.nsl, r.sel);
      begin
        while (sample_strobe !== 1'b1 && k < 3000) begin
          @(negedge pclk);
          k++;
        end
        if (k >= 3000)
          n_errors++;
        check("sample_out", {8'h0, sample_out}, {8'h0, x});
      end
    join
    apb(1'b0, ra(`ASP_IDX_DATA), 32'h0, q, e);
    check("data_reg", q, {7'h0, 1'b1, x});
    apb(1'b0, ra(`ASP_IDX_STATUS), 32'h0, q, e);
    check("status_after_row", q, 32'h8);
  endtask

  initial begin
    logic [31:0] q;
    logic e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    addr_select = 2'b10;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, ra(`ASP_IDX_CTRL1), 32'h0, q, e);
    check("ctrl1_reset", q, 32'h11);
    apb(1'b0, ra(`ASP_IDX_CTRL2), 32'h0, q, e);
    check("ctrl2_reset", q, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    check("unmapped", {q[30:0], e}, 32'h1);
    foreach (rows[i])
      run_row(rows[i]);
    // Fill past the four-word buffer with nobody draining
    apb(1'b1, ra(`ASP_IDX_CTRL1), 32'h11, q, e);
    apb(1'b1, ra(`ASP_IDX_CTRL2), 32'h00, q, e);
    u_asp_host_model.half_ns = 600;
    for (int i = 0; i < 5; i++)
      u_asp_host_model.send(8'h11, 8'h00, 24'(24'h111111 * (i + 1)), 32, 2, 0);
    apb(1'b0, ra(`ASP_IDX_STATUS), 32'h0, q, e);
    check("status_full", q, 32'hb);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra(`ASP_IDX_DATA), 32'h0, q, e);
      check("drain", q, {7'h0, 1'b1, 24'(24'h111111 * (i + 1))});
    end
    apb(1'b0, ra(`ASP_IDX_DATA), 32'h0, q, e);
    check("empty_valid", {31'h0, q[24]}, 32'h0);
    apb(1'b0, ra(`ASP_IDX_STATUS), 32'h0, q, e);
    check("status_drained", q, 32'h9);
    apb(1'b1, ra(`ASP_IDX_STATUS), 32'h1, q, e);
    apb(1'b0, ra(`ASP_IDX_STATUS), 32'h0, q, e);
    check("status_cleared", q, 32'h8);
    // Second reset in mid-run: registers and strap come back
    apb(1'b1, ra(`ASP_IDX_CTRL1), 32'h00, q, e);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, ra(`ASP_IDX_CTRL1), 32'h0, q, e);
    check("ctrl1_rereset", q, 32'h11);
    apb(1'b0, ra(`ASP_IDX_STATUS), 32'h0, q, e);
    check("status_rereset", q, 32'h8);
    report_and_stop;
  end
endmodule
